// ### rtl/ibwm_pkg.sv
`default_nettype none
package ibwm_pkg;

  // ----------------------------------------------------------------
  // Link framing
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_BURST_WRITE = 8'h28;
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam logic [7:0] ADDR_TOP        = 8'hff;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int NREG = 13;
  localparam logic [7:0] REG_OFS [NREG] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07,
    8'h09, 8'h0b, 8'h0d, 8'h0f, 8'h10, 8'h11};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Only digital_input_levels (index 9) is read-only
  localparam logic [NREG-1:0] REG_RO = 13'h0200;
  localparam int IDX_STATUS  = 0;
  localparam int IDX_GENERAL = 1;

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W     = 16;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_DEVADDR = 5'h02,
    ST_CMD     = 5'h04,
    ST_REGADDR = 5'h08,
    ST_DATA    = 5'h10
  } ibwm_state_e;

endpackage
`default_nettype wire

// ### rtl/ibwm_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ibwm_stream_if #(parameter int W = 16) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### rtl/ibwm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ibwm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  ibwm_stream_if.snk      in_s,
  ibwm_stream_if.src      out_s
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk_depth
    $error("ibwm_fifo: DEPTH must be a power of two of at least 2");
  end
  if ($bits(in_s.data) != WIDTH || $bits(out_s.data) != WIDTH) begin : g_chk_width
    $error("ibwm_fifo: stream width differs from WIDTH");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;

  wire full  = (wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  wire empty = (wptr_reg == rptr_reg);
  wire push  = in_s.valid & ~full;
  wire pop   = out_s.valid & out_s.ready;

  assign in_s.ready  = ~full;
  assign out_s.valid = ~empty;
  assign out_s.data  = mem[rptr_reg[AW-1:0]];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else if (ce) begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop)  rptr_reg <= rptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push) mem[wptr_reg[AW-1:0]] <= in_s.data;
  end

endmodule
`default_nettype wire

// ### rtl/ibwm_regbank.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Command byte 0x28 after an addressed write selects the burst register write.
// - The register address byte names the first register that gets data.
// - Each further data byte goes to the next higher location; pointer steps by one.
// - Data aimed at an unmapped location is dropped and changes nothing.
// - After the pointer passes the top of the address space, all data is dropped.
// - A stop or repeated start closes the burst write.
// - Reset loads system status with 0x81 and every other register with zero.
// - Registers live at 0x0-0x5, 0x7, 0x9, 0xb, 0xd, 0xf, 0x10, 0x11 only.
module ibwm_regbank
  import ibwm_pkg::*;
#(
  // Arbitrary default; set per board
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  input  wire logic       SCL_I,
  output logic            SCL_O,
  output logic            SCL_OE_N,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_N,
  input  wire logic [7:0] GPI_LEVELS,
  input  wire logic       WR_HOLD,
  input  wire logic [7:0] RD_ADDR,
  output logic      [7:0] RD_DATA,
  output logic            BURST_ACTIVE
);
  import ibwm_pkg::*;

  // ----------------------------------------------------------------
  // Line sampling and bus conditions
  // ----------------------------------------------------------------
  logic              scl_q_reg;
  logic              sda_q_reg;
  ibwm_state_e       state_reg;
  ibwm_state_e       state_next;
  logic [3:0]        cnt_reg;
  logic [7:0]        shift_reg;
  logic              ack_phase_reg;
  logic              ack_ok_reg;
  logic              ack_drive_reg;
  logic [7:0]        ptr_reg;
  logic              ovf_reg;
  logic              pend_reg;
  logic [WORD_W-1:0] pdata_reg;
  logic              hold_reg;
  logic [7:0]        rd_data_reg;
  logic [7:0]        regs_reg [NREG];

  wire scl_rise  = SCL_I & ~scl_q_reg;
  wire scl_fall  = ~SCL_I & scl_q_reg;
  wire start_det = scl_q_reg & SCL_I & sda_q_reg & ~SDA_I;
  wire stop_det  = scl_q_reg & SCL_I & ~sda_q_reg & SDA_I;
  wire [7:0] byte_in = {shift_reg[6:0], SDA_I};
  wire byte_done = scl_rise & ~ack_phase_reg & (cnt_reg == BYTE_BITS - 4'h1) &
                   (state_reg != ST_IDLE) & ~start_det & ~stop_det;

  wire addr_ok = (byte_in[7:1] == DEV_ADDR) & ~byte_in[0];
  wire cmd_ok  = (byte_in == CMD_BURST_WRITE);

  // Reads are not served here, so only a write addressing is acknowledged
  always_comb begin
    state_next = state_reg;
    if (start_det) begin
      state_next = ST_DEVADDR;
    end else if (stop_det) begin
      state_next = ST_IDLE;
    end else if (byte_done) begin
      unique case (state_reg)
        ST_IDLE:    state_next = ST_IDLE;
        ST_DEVADDR: state_next = addr_ok ? ST_CMD : ST_IDLE;
        ST_CMD:     state_next = cmd_ok ? ST_REGADDR : ST_IDLE;
        ST_REGADDR: state_next = ST_DATA;
        ST_DATA:    state_next = ST_DATA;
      endcase
    end
  end

  wire byte_ack = (state_reg == ST_DEVADDR) ? addr_ok :
                  (state_reg == ST_CMD)     ? cmd_ok  : 1'b1;

  // ----------------------------------------------------------------
  // Map decode for the write pointer
  // ----------------------------------------------------------------
  logic [NREG-1:0] ptr_hit;
  for (genvar i = 0; i < NREG; i++) begin : g_ptr_hit
    assign ptr_hit[i] = (ptr_reg == REG_OFS[i]);
  end
  wire ptr_mapped = |ptr_hit;
  wire data_done  = byte_done & (state_reg == ST_DATA);
  wire push_keep  = ptr_mapped & ~ovf_reg;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      state_reg <= ST_IDLE;
    end else if (CE) begin
      scl_q_reg <= SCL_I;
      sda_q_reg <= SDA_I;
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_reg       <= 4'h0;
      shift_reg     <= 8'h00;
      ack_phase_reg <= 1'b0;
      ack_ok_reg    <= 1'b0;
      ack_drive_reg <= 1'b0;
    end else if (CE) begin
      if (start_det || stop_det) begin
        cnt_reg       <= 4'h0;
        ack_phase_reg <= 1'b0;
        ack_drive_reg <= 1'b0;
      end else if (scl_rise && !ack_phase_reg && cnt_reg < BYTE_BITS) begin
        shift_reg <= byte_in;
        cnt_reg   <= cnt_reg + 4'h1;
        if (byte_done) ack_ok_reg <= byte_ack;
      end else if (scl_fall && ack_phase_reg) begin
        cnt_reg       <= 4'h0;
        ack_phase_reg <= 1'b0;
        ack_drive_reg <= 1'b0;
      end else if (scl_fall && cnt_reg == BYTE_BITS && state_reg != ST_IDLE) begin
        ack_phase_reg <= 1'b1;
        ack_drive_reg <= ack_ok_reg;
      end else if (scl_fall && cnt_reg == BYTE_BITS) begin
        cnt_reg <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write pointer and buffer feed
  // ----------------------------------------------------------------
  ibwm_stream_if #(.W(WORD_W)) push_if ();
  ibwm_stream_if #(.W(WORD_W)) pop_if ();

  assign push_if.valid = pend_reg;
  assign push_if.data  = pdata_reg;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ptr_reg <= 8'h00;
      ovf_reg <= 1'b0;
    end else if (CE) begin
      if (byte_done && state_reg == ST_REGADDR) begin
        ptr_reg <= byte_in;
        ovf_reg <= 1'b0;
      end else if (data_done) begin
        ptr_reg <= ptr_reg + 8'h01;
        if (ptr_reg == ADDR_TOP) ovf_reg <= 1'b1;
      end
    end
  end

  // A full buffer stretches the clock low instead of refusing the byte
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_reg  <= 1'b0;
      pdata_reg <= '0;
      hold_reg  <= 1'b0;
    end else if (CE) begin
      if (data_done) begin
        pend_reg  <= push_keep;
        pdata_reg <= {ptr_reg, byte_in};
      end else if (push_if.ready) begin
        pend_reg <= 1'b0;
      end
      hold_reg <= (scl_fall | hold_reg) & pend_reg & ~push_if.ready;
    end
  end

  ibwm_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .in_s  (push_if.snk),
    .out_s (pop_if.src)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  assign pop_if.ready = ~WR_HOLD;
  wire       pop_fire = pop_if.valid & pop_if.ready;
  wire [7:0] pop_addr = pop_if.data[15:8];
  wire [7:0] pop_data = pop_if.data[7:0];
  wire [7:0] rd_acc [NREG+1];
  assign rd_acc[0] = 8'h00;

  for (genvar i = 0; i < NREG; i++) begin : g_regs
    wire wr_hit = pop_fire & (pop_addr == REG_OFS[i]) & ~REG_RO[i];
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        regs_reg[i] <= REG_RST[i];
      end else if (CE) begin
        if (REG_RO[i]) regs_reg[i] <= GPI_LEVELS;
        else if (wr_hit) regs_reg[i] <= pop_data;
      end
    end
    assign rd_acc[i+1] = rd_acc[i] | ((RD_ADDR == REG_OFS[i]) ? regs_reg[i] : 8'h00);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) rd_data_reg <= 8'h00;
    else if (CE) rd_data_reg <= rd_acc[NREG];
  end

  // Open-drain lines: only ever pull low
  assign SCL_O        = 1'b0;
  assign SCL_OE_N     = ~hold_reg;
  assign SDA_O        = 1'b0;
  assign SDA_OE_N     = ~ack_drive_reg;
  assign RD_DATA      = rd_data_reg;
  assign BURST_ACTIVE = (state_reg == ST_DATA);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RESET_STATUS: assert property (@(posedge CLK) $rose(RST_N) |->
    regs_reg[IDX_STATUS] == REG_RST[IDX_STATUS] &&
    regs_reg[IDX_GENERAL] == REG_RST[IDX_GENERAL])
    else $error("status register not 0x81 after reset");
  AST_CMD_SELECT: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && byte_done && state_reg == ST_CMD |=> (state_reg == ST_REGADDR) == $past(cmd_ok))
    else $error("burst command decode wrong");
  AST_FIRST_PTR: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && byte_done && state_reg == ST_REGADDR |=> ptr_reg == $past(byte_in) && !ovf_reg)
    else $error("start address not loaded");
  AST_PTR_STEP: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && data_done |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("write pointer did not step by one");
  AST_UNMAPPED_DROP: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && data_done && !ptr_mapped |=> !pend_reg)
    else $error("unmapped byte queued");
  AST_OVF_DROP: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && data_done && ovf_reg |=> !pend_reg && ovf_reg)
    else $error("byte past address space queued");
  AST_CLOSE: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && (stop_det || start_det) |=> state_reg != ST_DATA && !ack_drive_reg)
    else $error("burst not closed by stop or repeated start");
  AST_DATA_ACK: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && scl_fall && !ack_phase_reg && cnt_reg == BYTE_BITS && state_reg == ST_DATA
    |=> !SDA_OE_N)
    else $error("data byte not acknowledged");
  AST_MAP_WRITE: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && pop_fire && pop_addr == REG_OFS[IDX_GENERAL]
    |=> regs_reg[IDX_GENERAL] == $past(pop_data))
    else $error("mapped register not written");

  // ----------------------------------------------------------------
  // Refusal, acknowledge and back-pressure checks
  // ----------------------------------------------------------------
  // A refused frame must leave the data line to the host, or another
  // device on the same wires would see a false acknowledge
  AST_ADDR_REFUSE: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && byte_done && state_reg == ST_DEVADDR && !addr_ok |=> state_reg == ST_IDLE)
    else $error("foreign or read address not refused");
  AST_CMD_REFUSE: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && byte_done && state_reg == ST_CMD && !cmd_ok
    |=> state_reg == ST_IDLE && !BURST_ACTIVE)
    else $error("other command entered the burst write");
  AST_NO_FALSE_ACK: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && scl_fall && !ack_phase_reg && cnt_reg == BYTE_BITS && state_reg == ST_IDLE
    |=> SDA_OE_N)
    else $error("refused byte acknowledged");
  AST_ACK_HELD: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && ack_phase_reg && !scl_fall && !start_det && !stop_det
    |=> ack_drive_reg == $past(ack_drive_reg))
    else $error("acknowledge changed inside the ninth clock");
  AST_ACK_RELEASE: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && scl_fall && ack_phase_reg |=> SDA_OE_N)
    else $error("acknowledge not released after ninth clock");
  // Stretching replaces a refusal, so it may only stand for a waiting byte
  AST_STRETCH_PEND: assert property (@(posedge CLK) disable iff (!RST_N)
    !SCL_OE_N |-> pend_reg)
    else $error("clock stretched with no byte waiting");
  AST_STRETCH_END: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && hold_reg && push_if.ready |=> SCL_OE_N)
    else $error("clock still stretched after buffer space opened");
  AST_PUSH_WORD: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && data_done && push_keep
    |=> pend_reg && pdata_reg == {$past(ptr_reg), $past(byte_in)})
    else $error("queued word does not pair pointer and data");
  AST_PTR_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && !data_done && !(byte_done && state_reg == ST_REGADDR) |=> $stable(ptr_reg))
    else $error("write pointer moved without a data byte");
  AST_WRAP_OVF: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && data_done && ptr_reg == ADDR_TOP |=> ovf_reg)
    else $error("pointer passed the top without overflow");

endmodule
`default_nettype wire

// ### test/ibwm_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Serial host model, open drain: a released line reads high
// ----------------------------------------------------------------
module ibwm_host (
  input  wire logic CLK,
  input  wire logic SCL_W,
  input  wire logic SDA_W,
  output logic      scl_rel,
  output logic      sda_rel
);
  int hp = 3;
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // Waits on the wire, so device clock stretching holds us back
  task automatic rise();
    scl_rel = 1'b1;
    for (int k = 0; k < 6000 && SCL_W !== 1'b1; k++) w(1);
    w(hp);
  endtask
  task automatic start();
    sda_rel = 1'b1;
    w(hp);
    rise();
    sda_rel = 1'b0;
    w(hp);
    scl_rel = 1'b0;
    w(hp);
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    w(hp);
    rise();
    sda_rel = 1'b1;
    w(hp);
  endtask
  // Eight bits MSB first plus the released ninth bit; ack is its sample
  task automatic bits(input logic [8:0] d, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_rel = d[i];
      w(hp);
      rise();
      ack = SDA_W;
      scl_rel = 1'b0;
      w(hp);
    end
  endtask
endmodule
`default_nettype wire

// ### test/i2c_burst_register_write_map_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_burst_register_write_map_tb_top;
  import ibwm_pkg::*;
  localparam logic [6:0] DA = 7'h2a;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        WR_HOLD = 1'b0;
  logic [7:0]  GPI = 8'h00;
  logic [7:0]  RD_ADDR = 8'h00;
  logic [7:0]  RD_DATA;
  logic        SCL_OE_N, SDA_OE_N, BURST_ACTIVE, h_scl, h_sda;
  wire         scl_w = h_scl & SCL_OE_N;
  wire         sda_w = h_sda & SDA_OE_N;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic        nack;
  int          exp_m [256];
  logic [31:0] rnd = 32'h067f39ca;
  logic [7:0]  ops [5] = '{8'h10, 8'h08, 8'h18, 8'h20, 8'h30};

  always #2.5 CLK = ~CLK;

  ibwm_regbank #(.DEV_ADDR(DA)) dut (.CLK(CLK), .RST_N(RST_N), .CE(1'b1),
    .SCL_I(scl_w), .SCL_O(), .SCL_OE_N(SCL_OE_N), .SDA_I(sda_w), .SDA_O(),
    .SDA_OE_N(SDA_OE_N), .GPI_LEVELS(GPI), .WR_HOLD(WR_HOLD), .RD_ADDR(RD_ADDR),
    .RD_DATA(RD_DATA), .BURST_ACTIVE(BURST_ACTIVE));
  ibwm_host host (.CLK(CLK), .SCL_W(scl_w), .SDA_W(sda_w), .scl_rel(h_scl),
    .sda_rel(h_sda));

  // ----------------------------------------------------------------
  // Reference model and helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic bit mapped(input int a);
    return a <= 5 || a == 7 || a == 9 || a == 11 || a == 13 || a == 15 || a == 16 || a == 17;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
    comparisons++;
    if (got !== want) begin
      errors++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic check_all();
    for (int a = 0; a < 256; a++) begin
      RD_ADDR = a[7:0];
      @(posedge CLK);
      #1;
      chk(RD_DATA, (a == 13) ? GPI : exp_m[a][7:0], "register");
    end
  endtask
  task automatic burst(input logic [7:0] cmd, input logic [7:0] ra, input int n, input bit sr);
    logic ack;
    int   p;
    host.start();
    host.bits({DA, 1'b0, 1'b1}, ack);
    chk({7'h0, ack}, 8'h00, "address ack");
    host.bits({cmd, 1'b1}, ack);
    chk({7'h0, ack}, (cmd == 8'h28) ? 8'h00 : 8'h01, "command ack");
    if (cmd == 8'h28) begin
      host.bits({ra, 1'b1}, ack);
      chk({7'h0, ack}, 8'h00, "reg address ack");
      for (int i = 0; i < n; i++) begin
        rnd = lfsr(rnd);
        p = ra + i;
        host.bits({rnd[7:0], 1'b1}, ack);
        chk({7'h0, ack}, 8'h00, "data ack");
        if (p < 256 && mapped(p) && p != 13) exp_m[p] = rnd[7:0];
      end
      chk({7'h0, BURST_ACTIVE}, 8'h01, "burst active");
    end
    if (sr) host.start();
    else host.stop();
    host.w(60);
    chk({7'h0, BURST_ACTIVE}, 8'h00, "burst closed");
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      $display("ERROR at %0t: run timed out", $time);
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    for (int a = 0; a < 256; a++) exp_m[a] = (a == 0) ? 8'h81 : 8'h00;
    repeat (12) @(posedge CLK);
    #1;
    RST_N = 1'b1;
    GPI = rnd[7:0];
    host.w(2);
    check_all();
    $display("test reset values done");
    // Writes stall so the buffer fills and the device stretches the clock
    WR_HOLD = 1'b1;
    fork
      begin
        // One burst queues at most 13 mapped bytes; the second fills the buffer
        burst(8'h28, 8'h00, 20, 1'b0);
        burst(8'h28, 8'h00, 5, 1'b0);
      end
      begin
        for (int k = 0; k < 20000 && SCL_OE_N !== 1'b0; k++) host.w(1);
        chk({7'h0, SCL_OE_N}, 8'h00, "stretch on full buffer");
        host.w(200);
        WR_HOLD = 1'b0;
      end
    join
    check_all();
    $display("test full burst done");
    host.hp = 6;
    rnd = lfsr(rnd);
    GPI = rnd[7:0];
    burst(8'h28, 8'hfc, 6, 1'b1);
    burst(8'h28, 8'h0d, 3, 1'b0);
    check_all();
    $display("test top of space done");
    host.hp = 3;
    for (int i = 0; i < 5; i++) burst(ops[i], 8'h01, 2, 1'b0);
    host.start();
    host.bits({DA, 1'b1, 1'b1}, nack);
    chk({7'h0, nack}, 8'h01, "read address refused");
    host.stop();
    host.w(20);
    check_all();
    $display("test other opcodes done");
    close_out();
  end
endmodule
`default_nettype wire
